/* rtl/usb_irq_map.vh */
// Register offsets, field positions, reset values and timing counts for the USB interrupt block.
`ifndef USB_IRQ_MAP_VH
`define USB_IRQ_MAP_VH

// Word byte offsets on the register bus.
`define OFS_FUNC_ADDR    8'h08
`define OFS_IRQ_EN_SET   8'h10
`define OFS_IRQ_EN_CLR   8'h14
`define OFS_IRQ_MASK     8'h18
`define OFS_IRQ_STATUS   8'h1C
`define OFS_IRQ_CLEAR    8'h20
`define OFS_LINK_CTRL    8'h24

// Field positions.
`define FADDR_MSB        6
`define FEN_BIT          8
`define BIT_SUSPEND      8
`define BIT_RESUME       9
`define BIT_EXT_RESUME   10
`define BIT_SOF          11
`define BIT_END_RESET    12
`define BIT_WAKEUP       13
`define NUM_EP           6

// Writable mask bits and clearable bus-event bits.
`define MASK_WRITABLE    14'h2F3F
`define EVENT_BITS       14'h3F00

// Reset values.
`define FADDR_RESET      7'h00
`define FEN_RESET        1'b1
`define MASK_RESET       14'h1200

// Idle time before suspend, and its cycle count at 25 MHz.
`define SUSPEND_IDLE_US  3000
`define CLK_MHZ          25
`define SUSPEND_CYCLES   (`SUSPEND_IDLE_US * `CLK_MHZ)

`endif

/* rtl/sync2.v */
// Two-flip-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps
module sync2 #(
	parameter W = 1
) (
	// Clock and reset.
	input  wire         clk,
	input  wire         rst_n,
	// Data.
	input  wire [W-1:0] asyncIn,
	output reg  [W-1:0] syncOut
);
	reg [W-1:0] meta_r;

	// The first stage feeds only the second stage.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r  <= {W{1'b0}};
			syncOut <= {W{1'b0}};
		end else begin
			meta_r  <= asyncIn;
			syncOut <= meta_r;
		end
	end
endmodule // sync2

/* rtl/idle_timer.v */
// Bus idle timer that flags suspend after a long quiet period.
`timescale 1ns/1ps
`include "usb_irq_map.vh"
module idle_timer #(
	parameter IDLE_CYCLES = `SUSPEND_CYCLES
) (
	// Clock and reset.
	input  wire clk,
	input  wire rst_n,
	// Bus activity and result.
	input  wire busActive,
	output reg  suspendPulse,
	output reg  suspended
);
	reg [23:0] count_r;

	// Count quiet cycles; one pulse when the limit is reached, held until activity.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r      <= 24'h00_0000;
			suspendPulse <= 1'b0;
			suspended    <= 1'b0;
		end else begin
			suspendPulse <= 1'b0;
			if (busActive) begin
				count_r   <= 24'h00_0000;
				suspended <= 1'b0;
			end else if (!suspended) begin
				if (count_r >= IDLE_CYCLES[23:0] - 24'h00_0001) begin
					suspendPulse <= 1'b1;
					suspended    <= 1'b1;
				end else begin
					count_r <= count_r + 24'h00_0001;
				end
			end
		end
	end
endmodule // idle_timer

/* rtl/usb_irq_ctrl.v */
// Interrupt mask, status and function address control with an Avalon-MM slave.
`timescale 1ns/1ps
`include "usb_irq_map.vh"
module usb_irq_ctrl #(
	parameter IDLE_CYCLES = `SUSPEND_CYCLES
) (
	// Clock and reset.
	input  wire        clk,
	input  wire        rst_n,
	// Avalon-MM slave.
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	output wire [1:0]  response,
	// Endpoint cause flags, one bit per endpoint, from the endpoint logic.
	input  wire [5:0]  setupReceivedFlag,
	input  wire [5:0]  rxBank0FullFlag,
	input  wire [5:0]  rxBank1FullFlag,
	input  wire [5:0]  txCompleteFlag,
	input  wire [5:0]  stallSentFlag,
	// Bus event inputs from the transceiver side, asynchronous.
	input  wire        busActivity,
	input  wire        resumeDetect,
	input  wire        extResumeDetect,
	input  wire        sofToken,
	input  wire        busResetActive,
	// Outputs.
	output wire        irq,
	output wire        functionEnable,
	output wire [6:0]  funcAddrValue,
	output wire        suspendMode
);
	reg  [6:0]  funcAddr_r;
	reg         fen_r;
	reg  [13:0] mask_r;
	reg  [13:8] evt_r;
	reg         ack_r;
	reg         resumeQ_r;
	reg         extQ_r;
	reg         sofQ_r;
	reg         rstQ_r;
	wire [4:0]  linkSync;
	wire        suspendPulse;
	wire [5:0]  epStatus;
	wire [13:0] status;
	wire        resumeRise;
	wire        extRise;
	wire        sofRise;
	wire        resetRise;
	wire        resetFall;
	wire        acc;
	wire        wrEn;
	wire        selFaddr;
	wire        selEnSet;
	wire        selEnClr;
	wire        selMask;
	wire        selStatus;
	wire        selClear;
	wire        selLinkCtl;

	// Asynchronous bus event lines pass two flip-flops before use.
	sync2 #(
		.W(5)
	) uSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn ({busActivity, resumeDetect, extResumeDetect, sofToken, busResetActive}),
		.syncOut (linkSync)
	);

	// Suspend detection on prolonged bus idle.
	idle_timer #(
		.IDLE_CYCLES(IDLE_CYCLES)
	) uIdle (
		.clk          (clk),
		.rst_n        (rst_n),
		.busActive    (linkSync[4]),
		.suspendPulse (suspendPulse),
		.suspended    (suspendMode)
	);

	// Delayed copies of synchronised lines for edge detection.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resumeQ_r <= 1'b0;
			extQ_r    <= 1'b0;
			sofQ_r    <= 1'b0;
			rstQ_r    <= 1'b0;
		end else begin
			resumeQ_r <= linkSync[3];
			extQ_r    <= linkSync[2];
			sofQ_r    <= linkSync[1];
			rstQ_r    <= linkSync[0];
		end
	end

	assign resumeRise = linkSync[3] & ~resumeQ_r;
	assign extRise    = linkSync[2] & ~extQ_r;
	assign sofRise    = linkSync[1] & ~sofQ_r;
	assign resetRise  = linkSync[0] & ~rstQ_r;
	assign resetFall  = ~linkSync[0] & rstQ_r;

	// Endpoint status follows its cause flags, so it holds until those are cleared.
	genvar e;
	generate
		for (e = 0; e < `NUM_EP; e = e + 1) begin : gEp
			assign epStatus[e] = setupReceivedFlag[e] | rxBank0FullFlag[e] |
			                     rxBank1FullFlag[e] | txCompleteFlag[e] | stallSentFlag[e];
		end
	endgenerate

	// Full status word; bits 6 and 7 are reserved and read zero.
	assign status = {evt_r, 2'b00, epStatus};

	// Request line while any pending source is enabled.
	assign irq = |(status & mask_r);

	// Register decode; two-cycle answer, one wait state removed by ack.
	assign acc        = (read | write) & ~ack_r;
	assign wrEn       = write & acc;
	assign selFaddr   = (address == `OFS_FUNC_ADDR);
	assign selEnSet   = (address == `OFS_IRQ_EN_SET);
	assign selEnClr   = (address == `OFS_IRQ_EN_CLR);
	assign selMask    = (address == `OFS_IRQ_MASK);
	assign selStatus  = (address == `OFS_IRQ_STATUS);
	assign selClear   = (address == `OFS_IRQ_CLEAR);
	assign selLinkCtl = (address == `OFS_LINK_CTRL);
	assign waitrequest = (read | write) & ~ack_r;
	assign response    = 2'b00;

	// Acknowledge one cycle after the request is seen, then drop.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= acc;
		end
	end

	// Read data is registered at the request cycle and stands at the ack edge.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= 32'h0000_0000;
		end else if (read & acc) begin
			if (selFaddr) begin
				readdata <= {23'h00_0000, fen_r, 1'b0, funcAddr_r};
			end else if (selMask) begin
				readdata <= {18'h0_0000, mask_r};
			end else if (selStatus) begin
				readdata <= {18'h0_0000, status};
			end else if (selLinkCtl) begin
				readdata <= {31'h0000_0000, suspendMode};
			end else begin
				readdata <= 32'h0000_0000;
			end
		end
	end

	// Function address and enable; the enable comes out of reset set, as its default value.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			funcAddr_r <= `FADDR_RESET;
			fen_r      <= `FEN_RESET;
		end else if (wrEn & selFaddr) begin
			if (byteenable[0]) begin
				funcAddr_r <= writedata[`FADDR_MSB:0];
			end
			if (byteenable[1]) begin
				fen_r <= writedata[`FEN_BIT];
			end
		end
	end

	assign funcAddrValue  = funcAddr_r;
	assign functionEnable = fen_r;

	// Mask: set and clear registers touch only writable bits; bit 12 stays high.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= `MASK_RESET;
		end else if (wrEn & selEnSet) begin
			mask_r <= mask_r | (writedata[13:0] & `MASK_WRITABLE);
		end else if (wrEn & selEnClr) begin
			mask_r <= mask_r & ~(writedata[13:0] & `MASK_WRITABLE);
		end
	end

	// Bus-event status: clear by writing one, and a same-cycle event wins over its clear.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_r <= 6'h00;
		end else begin
			if (wrEn & selClear) begin
				evt_r <= evt_r & ~writedata[13:8];
			end
			if (suspendPulse) begin
				evt_r[`BIT_SUSPEND] <= 1'b1;
			end
			if (resumeRise) begin
				evt_r[`BIT_RESUME] <= 1'b1;
			end
			if (extRise) begin
				evt_r[`BIT_EXT_RESUME] <= 1'b1;
			end
			if (sofRise) begin
				evt_r[`BIT_SOF] <= 1'b1;
			end
			if (resetFall) begin
				evt_r[`BIT_END_RESET] <= 1'b1;
			end
			if (resumeRise | resetRise) begin
				evt_r[`BIT_WAKEUP] <= 1'b1;
			end
		end
	end
endmodule // usb_irq_ctrl

/* tb/usb_irq_ctrl_checker.sv */
// Assertions on the ports of the USB interrupt and address block.
`timescale 1ns/1ps
module usb_irq_ctrl_checker #(
	parameter IDLE_CYCLES = 20
) (
	// Clock, reset and bus.
	input wire        clk,
	input wire        rst_n,
	input wire        read,
	input wire        write,
	input wire        waitrequest,
	input wire [1:0]  response,
	input wire [31:0] readdata,
	// Link and outputs.
	input wire        busActivity,
	input wire        functionEnable,
	input wire [6:0]  funcAddrValue,
	input wire        suspendMode
);
	// Quiet cycles counted on the raw line; it runs ahead of the synchroniser, a safe bound.
	reg [31:0] quiet_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			quiet_r <= 32'h0;
		else
			quiet_r <= busActivity ? 32'h0 : quiet_r + 32'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_wait_once: assert property ((read | write) && waitrequest |=> !waitrequest)
		else $error("wait state too long");
	a_wait_first: assert property ($rose(read | write) |-> waitrequest)
		else $error("request answered at once");
	a_resp_okay: assert property (response == 2'h0)
		else $error("bad response");
	a_addr_reset: assert property ($rose(rst_n) |-> funcAddrValue == 7'h0 && functionEnable)
		else $error("address not zero");
	a_addr_hold: assert property (!write |=> $stable(funcAddrValue))
		else $error("address moved without write");
	a_enable_hold: assert property (!write |=> $stable(functionEnable))
		else $error("enable moved without write");
	a_rdata_hold: assert property (!read |=> $stable(readdata))
		else $error("read data moved");
	a_susp_late: assert property ($rose(suspendMode) |-> quiet_r >= IDLE_CYCLES)
		else $error("suspend too early");
	a_susp_due: assert property (quiet_r == IDLE_CYCLES + 8 |-> suspendMode)
		else $error("suspend too late");
	a_wake_clears: assert property (busActivity [*5] |-> !suspendMode)
		else $error("suspend kept during activity");
	cover property ($rose(suspendMode));
	cover property (write && !waitrequest);
	cover property (read && !waitrequest);
endmodule // usb_irq_ctrl_checker
bind usb_irq_ctrl usb_irq_ctrl_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.clk(clk),
	.rst_n(rst_n), .read(read), .write(write), .waitrequest(waitrequest),
	.response(response), .readdata(readdata), .busActivity(busActivity),
	.functionEnable(functionEnable), .funcAddrValue(funcAddrValue), .suspendMode(suspendMode));

/* tb/usb_host_model.sv */
// Behavioural USB host that drives the bus event lines of the device.
`timescale 1ns/1ps
module usb_host_model (
	// Clock.
	input wire clk,
	// Bus event lines.
	output reg busActivity,
	output reg resumeDetect,
	output reg extResumeDetect,
	output reg sofToken,
	output reg busResetActive
);
	// Start busy, so the device does not suspend before firmware is ready.
	initial begin
		busActivity = 1'b1;
		{resumeDetect, extResumeDetect, sofToken, busResetActive} = 4'h0;
	end
	// Event held four cycles: 0 frame start, 1 resume, 2 bus reset, 3 external resume.
	task evt(input integer e);
		begin
			@(posedge clk);
			sofToken <= (e == 0);
			resumeDetect <= (e == 1);
			busResetActive <= (e == 2);
			extResumeDetect <= (e == 3);
			repeat (4) @(posedge clk);
			{resumeDetect, extResumeDetect, sofToken, busResetActive} <= 4'h0;
		end
	endtask
	// Bus traffic stops or restarts.
	task idle(input reg quiet);
		begin
			@(posedge clk);
			busActivity <= !quiet;
		end
	endtask
endmodule // usb_host_model

/* tb/usb_irq_ctrl_tb_top.sv */
// Self-checking bench for the USB interrupt and address block.
`timescale 1ns/1ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin failCount++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module usb_irq_ctrl_tb_top;
	localparam IDLE = 20;
	reg         clk = 0;
	reg         rst_n = 0;
	reg  [7:0]  address = 0;
	reg         read = 0;
	reg         write = 0;
	reg  [31:0] writedata = 0;
	reg  [31:0] rd;
	reg  [29:0] epFlags = 0;
	wire [31:0] readdata;
	wire [1:0]  response;
	wire [6:0]  funcAddrValue;
	wire        waitrequest, irq, functionEnable, suspendMode;
	wire        busActivity, resumeDetect, extResumeDetect, sofToken, busResetActive;
	integer     failCount = 0, nChecks = 0, cyc = 0, i;
	always #20 clk = ~clk;
	usb_irq_ctrl #(.IDLE_CYCLES(IDLE)) dut (.clk(clk), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
		.readdata(readdata), .waitrequest(waitrequest), .response(response),
		.setupReceivedFlag(epFlags[5:0]), .rxBank0FullFlag(epFlags[11:6]),
		.rxBank1FullFlag(epFlags[17:12]), .txCompleteFlag(epFlags[23:18]),
		.stallSentFlag(epFlags[29:24]), .busActivity(busActivity),
		.resumeDetect(resumeDetect), .extResumeDetect(extResumeDetect), .sofToken(sofToken),
		.busResetActive(busResetActive), .irq(irq), .functionEnable(functionEnable),
		.funcAddrValue(funcAddrValue), .suspendMode(suspendMode));
	usb_host_model host (.clk(clk), .busActivity(busActivity), .resumeDetect(resumeDetect),
		.extResumeDetect(extResumeDetect), .sofToken(sofToken), .busResetActive(busResetActive));
	// Prints the verdict; also the end of a hung run.
	task summarize;
		begin
			$display("checks %0d mismatches %0d", nChecks, failCount);
			if (failCount == 0 && nChecks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// The whole run needs well under this many cycles.
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 4000) begin
			failCount++;
			summarize;
		end
	end
	// One transfer, held until waitrequest is sampled low at a rising edge; data taken there.
	task xfer(input [7:0] a, input w, input [31:0] d);
		begin
			@(posedge clk);
			{address, writedata, write, read} <= {a, d, w, !w};
			@(posedge clk);
			while (waitrequest !== 1'b0) begin
				@(posedge clk);
			end
			rd = readdata;
			{write, read} <= 2'b00;
		end
	endtask
	task chkrd(input [7:0] a, input [31:0] e);
		begin
			xfer(a, 1'b0, 32'h0);
			`CHK(rd, e)
		end
	endtask
	// Status expected after each host event.
	function [31:0] evExp(input integer e);
		evExp = (e == 0) ? 32'h0800 : (e == 1) ? 32'h2200 : (e == 2) ? 32'h3000 : 32'h0400;
	endfunction
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		chkrd(8'h18, 32'h1200);
		chkrd(8'h08, 32'h0100);
		xfer(8'h20, 1, 32'h3F00);
		chkrd(8'h1C, 32'h0);
		xfer(8'h10, 1, 32'hFFFF);
		chkrd(8'h18, 32'h3F3F);
		xfer(8'h10, 1, 32'h0);
		xfer(8'h14, 1, 32'h1105);
		chkrd(8'h18, 32'h3E3A);
		xfer(8'h14, 1, 32'hFFFF);
		chkrd(8'h18, 32'h1000);
		$display("test mask done");
		xfer(8'h08, 1, 32'h017F);
		chkrd(8'h08, 32'h017F);
		`CHK({functionEnable, funcAddrValue}, 8'hFF)
		xfer(8'h08, 1, 32'h0055);
		xfer(8'h0C, 1, 32'hFFFF);
		chkrd(8'h0C, 32'h0);
		chkrd(8'h08, 32'h0055);
		$display("test address done");
		for (i = 0; i < 6; i = i + 1) begin
			xfer(8'h10, 1, 32'h1 << i);
			epFlags <= 30'h1 << (6 * (i % 5) + i);
			chkrd(8'h1C, 32'h1 << i);
			`CHK(irq, 1'b1)
			xfer(8'h20, 1, 32'h3FFF);
			chkrd(8'h1C, 32'h1 << i);
			epFlags <= 30'h0;
			xfer(8'h14, 1, 32'h1 << i);
			chkrd(8'h1C, 32'h0);
			`CHK(irq, 1'b0)
		end
		$display("test endpoint done");
		for (i = 0; i < 4; i = i + 1) begin
			host.evt(i);
			repeat (8) @(posedge clk);
			chkrd(8'h1C, evExp(i));
			`CHK(irq, i == 2)
			xfer(8'h20, 1, 32'h3F00);
			chkrd(8'h1C, 32'h0);
		end
		$display("test events done");
		host.idle(1);
		repeat (IDLE + 10) @(negedge clk);
		`CHK(suspendMode, 1'b1)
		chkrd(8'h1C, 32'h0100);
		chkrd(8'h24, 32'h1);
		`CHK(irq, 1'b0)
		xfer(8'h10, 1, 32'h0100);
		`CHK(irq, 1'b1)
		host.idle(0);
		repeat (6) @(negedge clk);
		`CHK(suspendMode, 1'b0)
		chkrd(8'h24, 32'h0);
		$display("test suspend done");
		@(posedge clk);
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		chkrd(8'h08, 32'h0100);
		chkrd(8'h18, 32'h1200);
		$display("test reset done");
		summarize;
	end
endmodule // usb_irq_ctrl_tb_top
